// ==== dv/acr_top_test.sv ====
// Self-checking bench for the converter control register block.
// Assumes acr_top is the only design under test, and that the bench itself plays
// both the Avalon master and the conversion engine.
`timescale 1ns/10ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))

module acr_top_test;
  // Clock, reset and all design inputs start defined at time zero
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] address_in = 4'h0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [3:0] byteenable_in = 4'hf;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic conv_done_in = 1'b0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic conv_start_out;
  logic conv_abort_out;
  logic converter_on_out;
  logic [4:0] channel_select_out;
  acr_pkg::acr_route_t route_out;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] v;

  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;

  acr_top u_dut (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .byteenable_in(byteenable_in),
    .writedata_in(writedata_in),
    .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out),
    .conv_done_in(conv_done_in),
    .conv_start_out(conv_start_out),
    .conv_abort_out(conv_abort_out),
    .converter_on_out(converter_on_out),
    .channel_select_out(channel_select_out),
    .route_out(route_out)
  );

  // Counts every comparison; case inequality so an unknown never matches
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer. An edge passes first, so a release and the next request
  // never share a time step; the request then holds until the rising edge at which
  // waitrequest is low, read data is taken at that edge and the request released
  task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [7:0] data,
                        output logic [31:0] rdata);
    @(posedge mclk_in);
    address_in <= addr;
    writedata_in <= {24'h00_0000, data};
    write_in <= wr;
    read_in <= ~wr;
    // Right after an edge the outputs still show what the slave had at that edge;
    // a slave that never answers is left to the watchdog
    @(posedge mclk_in);
    while (waitrequest_out !== 1'b0) begin
      @(posedge mclk_in);
    end
    rdata = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    logic [31:0] dummy;
    bus_op(1'b1, addr, data, dummy);
  endtask

  task automatic rd(input logic [3:0] addr, output logic [31:0] data);
    bus_op(1'b0, addr, 8'h00, data);
  endtask

  // One-cycle completion pulse from the engine
  task automatic engine_done();
    conv_done_in <= 1'b1;
    @(posedge mclk_in);
    conv_done_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // Control word and converter enable output come out of reset cleared
  task automatic test_reset();
    rd(4'h0, v);
    `CHK(v, 32'h0000_0000);
    @(negedge mclk_in);
    `CHK(converter_on_out, 1'b0);
    $display("test reset done");
  endtask

  // Channel field round trip and one-hot routing, special codes included
  task automatic test_channels();
    logic [4:0] codes [6] = '{5'h00, 5'h05, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
    foreach (codes[i]) begin
      wr(4'h0, {1'b0, codes[i], 2'b01});
      // Route lags the field by a cycle, so look one cycle later
      @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK(channel_select_out, codes[i]);
      `CHK(route_out, 32'h0000_0001 << codes[i]);
      @(posedge mclk_in);
      rd(4'h0, v);
      `CHK(v, {25'h000_0000, codes[i], 2'b01});
    end
    $display("test channels done");
  endtask

  // Go starts a conversion, reads busy, clears on completion
  task automatic test_conversion();
    wr(4'h0, 8'h0f);
    @(negedge mclk_in);
    `CHK(conv_start_out, 1'b1);
    @(posedge mclk_in);
    @(negedge mclk_in);
    `CHK(conv_start_out, 1'b0);
    @(posedge mclk_in);
    rd(4'h0, v);
    `CHK(v, 32'h0000_000f);
    engine_done();
    rd(4'h0, v);
    `CHK(v, 32'h0000_000d);
    $display("test conversion done");
  endtask

  // Disabling mid-conversion aborts; go with the converter off never starts
  task automatic test_disable();
    wr(4'h0, 8'h03);
    @(posedge mclk_in);
    wr(4'h0, 8'h02);
    @(negedge mclk_in);
    `CHK(conv_abort_out, 1'b1);
    `CHK(converter_on_out, 1'b0);
    @(posedge mclk_in);
    rd(4'h0, v);
    `CHK(v, 32'h0000_0000);
    wr(4'h0, 8'h02);
    @(negedge mclk_in);
    `CHK(conv_start_out, 1'b0);
    @(posedge mclk_in);
    $display("test disable done");
  endtask

  // Fixed reference, unused bit seven and an unmapped offset
  task automatic test_reference();
    wr(4'h0, 8'h7d);
    // Software leaves the acquisition time before converting the reference
    repeat (acr_pkg::ACR_FIXED_REF_ACQ_CYC) @(posedge mclk_in);
    @(negedge mclk_in);
    `CHK(route_out, 32'h8000_0000);
    wr(4'h0, 8'hff);
    wr(4'h4, 8'h00);
    rd(4'h4, v);
    `CHK(v, 32'h0000_0000);
    rd(4'h0, v);
    `CHK(v, 32'h0000_007f);
    engine_done();
    rd(4'h0, v);
    `CHK(v, 32'h0000_007d);
    $display("test reference done");
  endtask

  // Single place where the run ends
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    test_reset();
    test_channels();
    test_conversion();
    test_disable();
    test_reference();
    complete_run();
  end

  // Watchdog: the scenarios need about 1600 cycles, so this leaves a wide margin
  initial begin
    #100000;
    failures++;
    complete_run();
  end
endmodule

// ==== inc/acr_pkg.sv ====
// Package of the converter control register block: offsets, field layout,
// reset values, channel codes, states and the routing carrier.
// Assumes a 100 MHz single clock system and a 32-bit Avalon-MM register bus.
package acr_pkg;

  // Byte offset of the one control word on the bus
  localparam logic [3:0] ACR_OFS_CONTROL_0 = 4'h0;

  // Field positions inside the control word
  localparam int ACR_POS_ON = 0;
  localparam int ACR_POS_GO = 1;
  localparam int ACR_POS_CHAN_LO = 2;
  localparam int ACR_POS_CHAN_HI = 6;
  localparam int ACR_CHAN_W = 5;

  // Reset values of the control fields
  localparam logic [4:0] ACR_RST_CHAN = 5'h00;
  localparam logic ACR_RST_ON = 1'b0;
  localparam logic [31:0] ACR_RDATA_ZERO = 32'h0000_0000;

  // Channel codes: codes below the first special one are external inputs
  localparam int ACR_NUM_ANALOG = 28;
  localparam logic [4:0] ACR_CODE_RESERVED = 5'h1c;
  localparam logic [4:0] ACR_CODE_CTU = 5'h1d;
  localparam logic [4:0] ACR_CODE_DAC = 5'h1e;
  localparam logic [4:0] ACR_CODE_FIXED_REF = 5'h1f;
  localparam logic [27:0] ACR_ANALOG_ONE = 28'h000_0001;

  // Acquisition time that software leaves before converting the fixed reference
  localparam int ACR_CLK_MHZ = 100;
  localparam int ACR_FIXED_REF_ACQ_US = 15;
  localparam int ACR_FIXED_REF_ACQ_CYC = ACR_FIXED_REF_ACQ_US * ACR_CLK_MHZ;

  // Conversion sequencing states
  typedef enum logic [0:0] {
    ACR_IDLE,
    ACR_BUSY
  } acr_state_t;

  // One select line per possible converter input
  typedef struct packed {
    logic fixed_reference;
    logic dac_output;
    logic charge_time_unit;
    logic reserved_code;
    logic [27:0] analog_input;
  } acr_route_t;

  // Avalon request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } acr_bus_req_t;

endpackage

// ==== rtl/acr_chan_route.sv ====
// Channel code to input routing: turns the 5-bit selection into one select
// line per converter input, registered. Assumes the code comes from logic on
// the same clock, so no synchroniser is needed.
`timescale 1ns/10ps
module acr_chan_route (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [4:0] channel_select_in,
  output acr_pkg::acr_route_t route_out
);

  acr_pkg::acr_route_t route;
  acr_pkg::acr_route_t next_route;

  // Decode the code into exactly one select line
  always_comb begin
    next_route = '0;
    if (channel_select_in == acr_pkg::ACR_CODE_FIXED_REF) begin
      next_route.fixed_reference = 1'b1;
    end else if (channel_select_in == acr_pkg::ACR_CODE_DAC) begin
      next_route.dac_output = 1'b1;
    end else if (channel_select_in == acr_pkg::ACR_CODE_CTU) begin
      next_route.charge_time_unit = 1'b1;
    end else if (channel_select_in == acr_pkg::ACR_CODE_RESERVED) begin
      // Reserved code drives no analog input, only a flag
      next_route.reserved_code = 1'b1;
    end else begin
      // Ascending codes pick ascending external inputs
      next_route.analog_input = acr_pkg::ACR_ANALOG_ONE << channel_select_in;
    end
  end

  // Register the selection so the analog switches see a clean level
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      route <= '0;
    end else begin
      route <= next_route;
    end
  end

  assign route_out = route;

  // Fixed reference code routes the reference and no external input, one cycle later
  a_fixed_ref_route: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    channel_select_in == acr_pkg::ACR_CODE_FIXED_REF |=> route_out.fixed_reference
      && route_out.analog_input == '0)
    else $error("fixed reference code not routed");

  // External input code lights the matching input line
  a_analog_onehot: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    channel_select_in < acr_pkg::ACR_CODE_RESERVED |=>
      route_out.analog_input == (acr_pkg::ACR_ANALOG_ONE << $past(channel_select_in))
      && !route_out.fixed_reference)
    else $error("external input routing wrong");

endmodule

// ==== rtl/acr_top.sv ====
// Converter control register block: one software control word holding the
// channel selection, the conversion go bit and the converter enable, reached
// over an Avalon-MM slave with waitrequest.
// Assumes the conversion engine runs on mclk_in and pulses conv_done_in for
// one cycle when a conversion it was started on has finished.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module acr_top (
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Conversion engine
  input wire logic conv_done_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  // Analog front end
  output logic converter_on_out,
  output logic [4:0] channel_select_out,
  output acr_pkg::acr_route_t route_out
);

  // Bus request gathered into one carrier
  acr_pkg::acr_bus_req_t req;

  // Bus acknowledge phase and registered read data
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Control fields
  logic [4:0] channel_select;
  logic [4:0] next_channel_select;
  logic converter_on;
  logic next_converter_on;

  // Conversion sequencing
  acr_pkg::acr_state_t state;
  acr_pkg::acr_state_t next_state;
  logic start_pulse;
  logic next_start_pulse;
  logic abort_pulse;
  logic next_abort_pulse;

  // Decoded accesses and read image; wr_control is valid only in the cycle the write takes effect
  logic hit_control;
  logic wr_control;
  logic go_bit;
  logic [7:0] control_word;

  assign req.read = read_in;
  assign req.write = write_in;
  assign req.address = address_in;
  assign req.byteenable = byteenable_in;
  assign req.writedata = writedata_in;

  // Address decode; every other offset is unmapped
  always_comb begin
    hit_control = 1'b0;
    if (req.address == acr_pkg::ACR_OFS_CONTROL_0) begin
      hit_control = 1'b1;
    end else begin
      hit_control = 1'b0;
    end
  end

  // A write lands only in the ack cycle, when waitrequest is low
  assign wr_control = req.write && ack && hit_control && req.byteenable[0];

  // Go is not a stored bit: it is the busy state itself, so it cannot drift
  assign go_bit = (state == acr_pkg::ACR_BUSY);

  // Read image of the control word; bit seven is unimplemented
  always_comb begin
    control_word = 8'h00;
    control_word[acr_pkg::ACR_POS_CHAN_HI:acr_pkg::ACR_POS_CHAN_LO] = channel_select;
    control_word[acr_pkg::ACR_POS_GO] = go_bit;
    control_word[acr_pkg::ACR_POS_ON] = converter_on;
  end

  // Bus phase: one wait cycle, then the answer with data already registered
  always_comb begin
    next_ack = (req.read || req.write) && !ack;
    next_rdata = rdata;
    if ((req.read || req.write) && !ack) begin
      if (hit_control) begin
        next_rdata = {24'h00_0000, control_word};
      end else begin
        // Unmapped offsets read as zero
        next_rdata = acr_pkg::ACR_RDATA_ZERO;
      end
    end
  end

  // Register the bus phase
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack <= 1'b0;
      rdata <= acr_pkg::ACR_RDATA_ZERO;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Waitrequest falls in the cycle after the request appears
  assign waitrequest_out = (req.read || req.write) && !ack;
  assign readdata_out = rdata;

  // Control field next values
  always_comb begin
    next_channel_select = channel_select;
    next_converter_on = converter_on;
    if (wr_control) begin
      next_channel_select = req.writedata[acr_pkg::ACR_POS_CHAN_HI:acr_pkg::ACR_POS_CHAN_LO];
      next_converter_on = req.writedata[acr_pkg::ACR_POS_ON];
    end
  end

  // Register the control fields
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_select <= acr_pkg::ACR_RST_CHAN;
      converter_on <= acr_pkg::ACR_RST_ON;
    end else begin
      channel_select <= next_channel_select;
      converter_on <= next_converter_on;
    end
  end

  // Conversion sequencer. A go write is honoured only when the same write
  // leaves the converter enabled; starting a powered-down converter would
  // give a meaningless result. Switching off mid-conversion aborts it.
  always_comb begin
    next_state = state;
    next_start_pulse = 1'b0;
    next_abort_pulse = 1'b0;
    case (state)
      acr_pkg::ACR_IDLE: begin
        if (wr_control && req.writedata[acr_pkg::ACR_POS_GO] && req.writedata[acr_pkg::ACR_POS_ON]) begin
          next_state = acr_pkg::ACR_BUSY;
          next_start_pulse = 1'b1;
        end
      end
      acr_pkg::ACR_BUSY: begin
        if (wr_control && !req.writedata[acr_pkg::ACR_POS_ON]) begin
          // Disable wins over everything and stops the engine
          next_state = acr_pkg::ACR_IDLE;
          next_abort_pulse = 1'b1;
        end else if (conv_done_in) begin
          // Completion clears go with no software action
          next_state = acr_pkg::ACR_IDLE;
        end
      end
      default: begin
        next_state = acr_pkg::ACR_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= acr_pkg::ACR_IDLE;
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
    end else begin
      state <= next_state;
      start_pulse <= next_start_pulse;
      abort_pulse <= next_abort_pulse;
    end
  end

  assign conv_start_out = start_pulse;
  assign conv_abort_out = abort_pulse;
  assign converter_on_out = converter_on;
  assign channel_select_out = channel_select;

  // Select lines for the analog multiplexer. Software must itself allow the
  // acquisition time before converting the fixed reference; this block does
  // not delay the start for it.
  acr_chan_route u_route (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .channel_select_in(channel_select),
    .route_out(route_out)
  );

  // Step sequences of a conversion
  sequence s_go_write;
    wr_control && req.writedata[acr_pkg::ACR_POS_GO] && req.writedata[acr_pkg::ACR_POS_ON]
      && state == acr_pkg::ACR_IDLE;
  endsequence

  sequence s_started;
    conv_start_out && go_bit;
  endsequence

  // Steps of a switch-off: the write, then one abort pulse with go already low
  sequence s_off_write;
    wr_control && !req.writedata[acr_pkg::ACR_POS_ON];
  endsequence

  sequence s_aborted;
    conv_abort_out && !converter_on_out && !go_bit ##1 !conv_abort_out;
  endsequence

  // A go write starts exactly one conversion on the next edge
  a_go_starts: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_go_write |=> s_started ##1 !conv_start_out)
    else $error("go write did not start a conversion");

  // Go stays readable as one until completion or abort
  a_go_holds: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    go_bit && !conv_done_in && !(wr_control && !req.writedata[acr_pkg::ACR_POS_ON]) |=> go_bit)
    else $error("go dropped while converting");

  // Completion clears go on the next edge
  a_done_clears: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    go_bit && conv_done_in |=> !go_bit)
    else $error("go not cleared at completion");

  // Go never reads one with the converter disabled
  a_off_idle: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !converter_on_out |-> !go_bit)
    else $error("conversion running while disabled");

  // Disable during a conversion aborts it in one cycle
  a_off_aborts: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    go_bit && wr_control && !req.writedata[acr_pkg::ACR_POS_ON] |=> conv_abort_out && !converter_on_out)
    else $error("disable did not abort conversion");

  // Bits six to two of a write land in the channel select output
  a_chan_field: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    wr_control |=> channel_select_out == $past(req.writedata[acr_pkg::ACR_POS_CHAN_HI:acr_pkg::ACR_POS_CHAN_LO]))
    else $error("channel field not stored from bits six to two");

  // Read answer carries go in bit one, one cycle after the request
  a_read_go: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    req.read && !ack && hit_control |=> !waitrequest_out && readdata_out[acr_pkg::ACR_POS_GO] == $past(go_bit))
    else $error("read of go bit wrong");

  // A switch-off during a conversion gives one abort pulse and idles the sequencer
  a_off_sequence: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    go_bit ##0 s_off_write |=> s_aborted)
    else $error("switch-off did not end the conversion cleanly");

  // A write that leaves the converter off can never start it
  a_off_no_start: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_off_write |=> !conv_start_out && !go_bit)
    else $error("conversion started with the converter off");

  // Enable bit of a write lands in the converter enable output
  a_on_stored: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    wr_control |=> converter_on_out == $past(req.writedata[acr_pkg::ACR_POS_ON]))
    else $error("converter enable not stored from bit zero");

  // Channel field only moves on a write to the control word
  a_chan_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !wr_control |=> $stable(channel_select_out))
    else $error("channel field changed without a write");

  // Unmapped writes touch neither field; the decode must not alias offsets
  a_wr_unmapped: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    req.write && ack && !hit_control |=> $stable(channel_select_out) && $stable(converter_on_out))
    else $error("unmapped write changed a control field");

  // Completion while idle is ignored unless a go write lands in the same cycle
  a_done_idle: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !go_bit && conv_done_in && !(wr_control && req.writedata[acr_pkg::ACR_POS_GO]
      && req.writedata[acr_pkg::ACR_POS_ON]) |=> !go_bit)
    else $error("idle completion set go");

  // A running conversion never issues a second start
  a_no_restart: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    go_bit |=> !conv_start_out)
    else $error("second start while converting");

  // Bits above the channel field read as zero; bit seven is not implemented
  a_upper_zero: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    readdata_out[31:7] == '0)
    else $error("unimplemented read bits not zero");

  // Every request is answered after exactly one wait cycle
  a_bus_answer: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (req.read || req.write) && !ack |=> !waitrequest_out)
    else $error("bus request not answered after one wait cycle");

endmodule
